// [verilog/itc_ctrl.v]
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "itc_map.vh"

// Summary of operation
// RQ1: state code register keeps low three bits zero, upper five hold code.
// RQ2: idle code f8 never raises the serial event flag.
// RQ3: entering any defined bus state sets the serial event flag.
// RQ4: code valid with the flag, kept until a cycle after flag clear.
// RQ5: start or stop inside a byte or acknowledge reports code 00.
// RQ6: timeout counter runs only with count enable and interface enable.
// RQ7: serial event flag stops the timeout counter and clears it.
// RQ8: timeout counter ticks every clock, or every fourth with prescale.
// RQ9: counter overflow sets a sticky flag cleared only by software.
// RQ10: overflow flag raises the interrupt when its mask bit allows.
// RQ11: software clears the event flag before starting the timeout counter.
// RQ12: control register holds enable, start, stop, event, ack at 6..2.
// RQ13: slave answers own seven-bit address, general call when enabled.
// RQ14: start, address, data, ack, stop follow the two-wire protocol.
module itc_ctrl (
	input wire clk_in,
	input wire nrst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output wire pready_out,
	output reg pslverr_out,
	output reg irq_out,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe_out,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_out
);

// -------------------------------------------------------------
// declarations
// -------------------------------------------------------------
localparam MS_IDLE = 4'b0001;
localparam MS_START = 4'b0010;
localparam MS_RUN = 4'b0100;
localparam MS_STOP = 4'b1000;

reg scl_m1, scl_s, scl_p, sda_m1, sda_s, sda_p;
reg ens, begin_condition_request, end_condition_request, si, aa, si_d;
reg [7:0] data, code, rate, own;
reg timeout_count_enable, timeout_prescale_select, timeout_overflow_flag;
reg [1:0] ist, imsk, pre, ph;
reg [13:0] tmo;
reg [3:0] mst, cnt;
reg [7:0] qcnt;
reg mscl, msda, scl_lo, sda_lo, rep;
reg active, master, first, tx, gc_hit, ackb, busy;

function reg_hit;
	input [11:0] a;
	input [7:0] idx;
	begin
		reg_hit = (a == {2'b00, idx, 2'b00});
	end
endfunction

// -------------------------------------------------------------
// pin synchronisers and bus condition detection
// -------------------------------------------------------------
// two flops before any logic sees the open-drain lines
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		scl_m1 <= 1'b1;
		scl_s <= 1'b1;
		scl_p <= 1'b1;
		sda_m1 <= 1'b1;
		sda_s <= 1'b1;
		sda_p <= 1'b1;
	end else begin
		scl_m1 <= scl_in;
		scl_s <= scl_m1;
		scl_p <= scl_s;
		sda_m1 <= sda_in;
		sda_s <= sda_m1;
		sda_p <= sda_s;
	end
end

wire scl_rise = scl_s & ~scl_p;
wire scl_fall = ~scl_s & scl_p;
wire start_det = scl_s & scl_p & sda_p & ~sda_s;
wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
wire gen = mst[1] | mst[3];
// a restart or stop is legal only during the first bit of a byte
wire bus_err = active & (cnt > 4'd1) & ~gen; // see RQ5
wire addressed = active & ~master & ~first;
wire gc_now = own[0] & (data == 8'h00); // see RQ13
wire match = (data[7:1] == own[7:1]) | gc_now; // see RQ13
wire ack = ~ackb;
wire bit_now = data[3'd7 - cnt[2:0]];
wire drv_bit = active & ~si & (((cnt < 4'd8) & tx & ~bit_now) |
	((cnt == 4'd8) & ~tx & aa & (~first | match))); // see RQ14

// -------------------------------------------------------------
// apb slave
// -------------------------------------------------------------
wire wr_en = psel_in & penable_in & pwrite_in;
wire setup = psel_in & ~penable_in;
assign pready_out = 1'b1;

// read data is captured in the setup cycle so it leaves a flop
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		prdata_out <= 32'h0000_0000;
		pslverr_out <= 1'b0;
	end else if (setup) begin
		pslverr_out <= 1'b0;
		if (reg_hit(paddr_in, `ITC_IDX_DATA)) begin
			prdata_out <= {24'h00_0000, data};
		end else if (reg_hit(paddr_in, `ITC_IDX_STATE)) begin
			prdata_out <= {24'h00_0000, code}; // see RQ1
		end else if (reg_hit(paddr_in, `ITC_IDX_RATE)) begin
			prdata_out <= {24'h00_0000, rate};
		end else if (reg_hit(paddr_in, `ITC_IDX_TMO)) begin
			prdata_out <= {29'h0000_0000, timeout_count_enable, timeout_prescale_select, timeout_overflow_flag};
		end else if (reg_hit(paddr_in, `ITC_IDX_CON)) begin
			prdata_out <= {25'h000_0000, ens, begin_condition_request, end_condition_request, si, aa,
				2'b00}; // see RQ12
		end else if (reg_hit(paddr_in, `ITC_IDX_OWN)) begin
			prdata_out <= {24'h00_0000, own};
		end else if (reg_hit(paddr_in, `ITC_IDX_IST)) begin
			prdata_out <= {30'h0000_0000, ist};
		end else if (reg_hit(paddr_in, `ITC_IDX_IMSK)) begin
			prdata_out <= {30'h0000_0000, imsk};
		end else begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b1;
		end
	end
end

// -------------------------------------------------------------
// quarter-bit timebase for the master clock
// -------------------------------------------------------------
// released clock held low by someone else stalls the timebase
wire q_wait = ~scl_lo & ~scl_s;
wire qtick = (qcnt == rate) & ~q_wait; // see RQ14
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		qcnt <= 8'h00;
	end else if (q_wait | qtick | mst[0]) begin
		qcnt <= 8'h00;
	end else begin
		qcnt <= qcnt + 8'h01;
	end
end

// -------------------------------------------------------------
// control registers, master sequencer and bit engine
// -------------------------------------------------------------
// hardware updates come after software writes so hardware wins
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		ens <= 1'b0;
		begin_condition_request <= 1'b0;
		end_condition_request <= 1'b0;
		si <= 1'b0;
		aa <= 1'b0;
		si_d <= 1'b0;
		data <= 8'h00;
		code <= `ITC_ST_IDLE;
		rate <= 8'h00;
		own <= 8'h00;
		mst <= MS_IDLE;
		ph <= 2'd0;
		mscl <= 1'b0;
		msda <= 1'b0;
		rep <= 1'b0;
		scl_lo <= 1'b0;
		sda_lo <= 1'b0;
		active <= 1'b0;
		master <= 1'b0;
		first <= 1'b0;
		tx <= 1'b0;
		gc_hit <= 1'b0;
		ackb <= 1'b1;
		busy <= 1'b0;
		cnt <= 4'd0;
	end else begin
		si_d <= si;
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_CON)) begin
			ens <= pwdata_in[`ITC_CON_ENS]; // see RQ12
			begin_condition_request <= pwdata_in[`ITC_CON_STA];
			end_condition_request <= pwdata_in[`ITC_CON_STO];
			aa <= pwdata_in[`ITC_CON_AA];
			if (!pwdata_in[`ITC_CON_SI])
				si <= 1'b0;
		end
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_DATA))
			data <= pwdata_in[7:0];
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_RATE))
			rate <= pwdata_in[7:0];
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_OWN))
			own <= pwdata_in[7:0];
		// code falls back to idle one cycle after the flag clears
		if (si_d & ~si)
			code <= `ITC_ST_IDLE; // see RQ4
		if (scl_rise & active & (cnt < 4'd9))
			cnt <= cnt + 4'd1;
		// master sequencer
		case (mst)
		MS_IDLE: begin
			mscl <= 1'b0;
			msda <= 1'b0;
			if (ens & begin_condition_request & ~busy & ~si) begin
				mst <= MS_START;
				ph <= 2'd0;
				rep <= 1'b0;
				master <= 1'b0;
			end
		end
		MS_RUN: begin
			if (~master) begin
				mst <= MS_IDLE;
			end else if (~si & begin_condition_request & (cnt == 4'd0)) begin
				mst <= MS_START;
				ph <= 2'd0;
				rep <= 1'b1;
				msda <= 1'b0;
				master <= 1'b0;
			end else if (~si & end_condition_request & (cnt == 4'd0)) begin
				mst <= MS_STOP;
				ph <= 2'd0;
				msda <= 1'b1;
			end else if (qtick & ~(si & mscl)) begin
				// hold the clock low while the event flag is set
				ph <= ph + 2'd1;
				if (ph[0])
					mscl <= ~mscl; // see RQ14
			end
		end
		default: begin
			if (qtick) begin
				case (ph)
				2'd0: ph <= 2'd1;
				2'd1: begin
					mscl <= 1'b0;
					ph <= 2'd2;
				end
				2'd2: begin
					msda <= mst[1];
					ph <= 2'd3;
				end
				default: begin
					if (mst[1] & master) begin
						mscl <= 1'b1;
						mst <= MS_RUN;
						ph <= 2'd0;
					end
				end
				endcase
			end
		end
		endcase
		// bit engine: sample on rise
		if (scl_rise & active) begin
			if (cnt < 4'd8) begin
				if (~tx) begin
					data <= {data[6:0], sda_s};
				end else if (master & bit_now & ~sda_s) begin
					si <= 1'b1;
					code <= `ITC_ST_ARB_LOST;
					master <= 1'b0;
					active <= 1'b0;
				end
			end else if (cnt == 4'd8) begin
				ackb <= sda_s;
			end
		end
		// byte complete after the acknowledge clock falls
		if (scl_fall & active & (cnt == 4'd9)) begin
			cnt <= 4'd0;
			first <= 1'b0;
			if (master) begin
				si <= 1'b1; // see RQ3
				if (first) begin
					tx <= ~data[0];
					if (data[0])
						code <= ack ? `ITC_ST_MR_SLA_ACK :
							`ITC_ST_MR_SLA_NACK;
					else
						code <= ack ? `ITC_ST_MT_SLA_ACK :
							`ITC_ST_MT_SLA_NACK;
				end else if (tx) begin
					code <= ack ? `ITC_ST_MT_DAT_ACK :
						`ITC_ST_MT_DAT_NACK;
				end else begin
					code <= ack ? `ITC_ST_MR_DAT_ACK :
						`ITC_ST_MR_DAT_NACK;
				end
			end else if (first) begin
				// only our own address or an enabled general call, acknowledged, wakes software
				if (match & aa) begin
					si <= 1'b1; // see RQ13
					gc_hit <= gc_now;
					tx <= data[0] & ~gc_now;
					if (gc_now)
						code <= `ITC_ST_SR_GC_ACK;
					else if (data[0])
						code <= `ITC_ST_ST_SLA_ACK;
					else
						code <= `ITC_ST_SR_SLA_ACK;
				end else begin
					active <= 1'b0;
				end
			end else begin
				si <= 1'b1; // see RQ3
				if (~ack)
					active <= 1'b0;
				if (tx)
					code <= ack ? `ITC_ST_ST_DAT_ACK :
						`ITC_ST_ST_DAT_NACK;
				else if (gc_hit)
					code <= ack ? `ITC_ST_SR_GC_DAT_ACK :
						`ITC_ST_SR_GC_DAT_NACK;
				else
					code <= ack ? `ITC_ST_SR_DAT_ACK :
						`ITC_ST_SR_DAT_NACK;
			end
		end
		// start and stop conditions
		if (start_det | stop_det)
			busy <= start_det;
		if ((start_det | stop_det) & bus_err) begin
			si <= 1'b1;
			code <= `ITC_ST_BUSERR; // see RQ5
			active <= 1'b0;
			master <= 1'b0;
			mst <= MS_IDLE;
			end_condition_request <= 1'b0;
		end else if (start_det) begin
			active <= 1'b1;
			first <= 1'b1;
			cnt <= 4'd0;
			gc_hit <= 1'b0;
			if (mst[1]) begin
				tx <= 1'b1;
				master <= 1'b1;
				begin_condition_request <= 1'b0;
				si <= 1'b1; // see RQ3
				code <= rep ? `ITC_ST_RSTART : `ITC_ST_START;
			end else begin
				tx <= 1'b0;
				master <= 1'b0;
				if (addressed) begin
					si <= 1'b1;
					code <= `ITC_ST_SR_STOP;
				end
			end
		end else if (stop_det) begin
			active <= 1'b0;
			master <= 1'b0;
			if (addressed) begin
				si <= 1'b1;
				code <= `ITC_ST_SR_STOP;
			end
			if (mst[3]) begin
				end_condition_request <= 1'b0;
				mst <= MS_IDLE;
			end
		end
		// line drivers; outside start and stop generation, data only moves while the clock is low
		scl_lo <= mscl | (si & active & ~master);
		if (gen)
			sda_lo <= msda;
		else if (~scl_s)
			sda_lo <= drv_bit; // see RQ14
		if (!ens) begin
			active <= 1'b0;
			master <= 1'b0;
			mst <= MS_IDLE;
			scl_lo <= 1'b0;
			sda_lo <= 1'b0;
		end
	end
end

assign scl_out = 1'b0;
assign sda_out = 1'b0;
assign scl_oe_out = scl_lo;
assign sda_oe_out = sda_lo;

// -------------------------------------------------------------
// 14-bit timeout counter
// -------------------------------------------------------------
wire tmo_run = timeout_count_enable & ens; // see RQ6
wire tmo_step = timeout_prescale_select ? (pre == `ITC_PRE_TIMEOUT_PRESCALE_SELECT) : 1'b1; // see RQ8
// a stuck bus while the flag is clear ends in an overflow
wire tmo_ovf = tmo_run & ~si & tmo_step & (tmo == `ITC_TMO_MAX);
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		pre <= 2'd0;
		tmo <= 14'h0000;
		timeout_count_enable <= 1'b0;
		timeout_prescale_select <= 1'b0;
		timeout_overflow_flag <= 1'b0;
	end else begin
		pre <= pre + 2'd1;
		if (si)
			tmo <= 14'h0000; // see RQ7
		else if (tmo_run & tmo_step)
			tmo <= tmo + 14'h0001; // see RQ6
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_TMO)) begin
			timeout_count_enable <= pwdata_in[`ITC_TMO_EN];
			timeout_prescale_select <= pwdata_in[`ITC_TMO_DIV];
			if (!pwdata_in[`ITC_TMO_OVF])
				timeout_overflow_flag <= 1'b0;
		end
		if (tmo_ovf)
			timeout_overflow_flag <= 1'b1; // see RQ9
	end
end

// -------------------------------------------------------------
// interrupt status, mask and request
// -------------------------------------------------------------
wire [1:0] ist_set = {tmo_ovf, si & ~si_d};
wire [1:0] ist_clr = (wr_en & reg_hit(paddr_in, `ITC_IDX_IST)) ?
	pwdata_in[1:0] : 2'b00;
always @(posedge clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		ist <= 2'b00;
		imsk <= 2'b00;
		irq_out <= 1'b0;
	end else begin
		ist <= (ist & ~ist_clr) | ist_set; // see RQ2
		if (wr_en & reg_hit(paddr_in, `ITC_IDX_IMSK))
			imsk <= pwdata_in[1:0];
		irq_out <= |(ist & imsk); // see RQ10
	end
end

endmodule
`default_nettype wire

// [verilog/itc_map.vh]
`ifndef ITC_MAP_VH
`define ITC_MAP_VH
// register indices; byte address is four times the index
`define ITC_IDX_DATA 8'hbc
`define ITC_IDX_STATE 8'hbd
`define ITC_IDX_RATE 8'hbe
`define ITC_IDX_TMO 8'hbf
`define ITC_IDX_CON 8'hc0
`define ITC_IDX_OWN 8'hc1
`define ITC_IDX_IST 8'hd0
`define ITC_IDX_IMSK 8'hd1
// bus_control bits
`define ITC_CON_ENS 6
`define ITC_CON_STA 5
`define ITC_CON_STO 4
`define ITC_CON_SI 3
`define ITC_CON_AA 2
// timeout_control bits
`define ITC_TMO_EN 2
`define ITC_TMO_DIV 1
`define ITC_TMO_OVF 0
// interrupt status bits
`define ITC_IRQ_SI 0
`define ITC_IRQ_TMO 1
// timeout counter
`define ITC_TMO_MAX 14'h3fff
`define ITC_PRE_TIMEOUT_PRESCALE_SELECT 2'h3
// state codes
`define ITC_ST_BUSERR 8'h00
`define ITC_ST_START 8'h08
`define ITC_ST_RSTART 8'h10
`define ITC_ST_MT_SLA_ACK 8'h18
`define ITC_ST_MT_SLA_NACK 8'h20
`define ITC_ST_MT_DAT_ACK 8'h28
`define ITC_ST_MT_DAT_NACK 8'h30
`define ITC_ST_ARB_LOST 8'h38
`define ITC_ST_MR_SLA_ACK 8'h40
`define ITC_ST_MR_SLA_NACK 8'h48
`define ITC_ST_MR_DAT_ACK 8'h50
`define ITC_ST_MR_DAT_NACK 8'h58
`define ITC_ST_SR_SLA_ACK 8'h60
`define ITC_ST_SR_GC_ACK 8'h70
`define ITC_ST_SR_DAT_ACK 8'h80
`define ITC_ST_SR_DAT_NACK 8'h88
`define ITC_ST_SR_GC_DAT_ACK 8'h90
`define ITC_ST_SR_GC_DAT_NACK 8'h98
`define ITC_ST_SR_STOP 8'ha0
`define ITC_ST_ST_SLA_ACK 8'ha8
`define ITC_ST_ST_DAT_ACK 8'hb8
`define ITC_ST_ST_DAT_NACK 8'hc0
`define ITC_ST_IDLE 8'hf8
`endif

// [verif/itc_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// far-side slave that answers each byte
// ----
module itc_peer (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	output logic ack_oe_out
);
	int cnt = 0;
	// start condition restarts the count
	always @(negedge sda_in) begin
		if (scl_in) begin
			cnt = -1;
		end
	end
	// pull data low over the ninth clock unless refusing
	always @(negedge scl_in) begin
		cnt = (cnt == 9) ? 1 : cnt + 1;
		ack_oe_out = (cnt == 8) && !nack_in;
	end
	initial ack_oe_out = 0; // released: pull-up wins
endmodule
`default_nettype wire

// [verif/itc_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module itc_ctrl_chk (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic irq_out,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out
);
	logic acc;
	logic [7:0] msk;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// access phase
	assign acc = psel_in && penable_in;
	// mask copy; irq trails it by a cycle
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			msk <= 8'h00;
		end else if (acc && pwrite_in && paddr_in == 12'h344) begin
			msk <= pwdata_in[7:0];
		end
	end
	state_low_a: assert property (acc && paddr_in == 12'h2f4 |->
		prdata_out[2:0] == 3'h0) else $error("state low bits set");
	ctl_rsvd_a: assert property (acc && paddr_in == 12'h300 |->
		prdata_out[7] == 1'b0 && prdata_out[1:0] == 2'h0)
		else $error("control reserved bits set");
	tmo_rsvd_a: assert property (acc && paddr_in == 12'h2fc |->
		prdata_out[7:3] == 5'h00) else $error("timeout reserved set");
	word_high_a: assert property (acc |->
		prdata_out[31:8] == 24'h0) else $error("upper bits set");
	bad_addr_a: assert property (acc && paddr_in == 12'h000 |->
		pslverr_out && prdata_out == 32'h0) else $error("no slave error");
	mask_quiet_a: assert property (msk[1:0] == 2'h0 |=>
		!irq_out) else $error("irq while masked");
	read_stands_a: assert property (acc |=>
		$stable(prdata_out)) else $error("read data moved");
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	clk_low_a: assert property ($rose(scl_oe_out) |->
		scl_oe_out [*2]) else $error("clock low too short");
	cover property ($rose(irq_out));
	cover property (acc && paddr_in == 12'h2f4 && prdata_out == 32'h18);
	cover property ($rose(pslverr_out));
endmodule
bind itc_ctrl itc_ctrl_chk u_chk (.*);
`default_nettype wire

// [verif/itc_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "itc_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
// ----
// bench top
// ----
module itc_ctrl_test;
	logic clk_in = 0;
	logic nrst_in = 0;
	logic psel_in = 0;
	logic penable_in = 0;
	logic pwrite_in = 0;
	logic [11:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, irq_out, er, nack = 0;
	logic scl_out, scl_oe_out, sda_out, sda_oe_out, ack_oe;
	int err_total = 0, checks_done = 0, cyc = 0, seed = 32'h1db6;
	int i, j, n;
	int m [256];
	int rw [3] = '{8'hbc, 8'hbe, 8'hc1};
	// open-drain lines with pull-ups
	wire scl = scl_oe_out ? scl_out : 1'b1;
	wire sda = sda_oe_out ? sda_out : !ack_oe;
	itc_ctrl u_dut (.*, .scl_in(scl), .sda_in(sda));
	itc_peer u_peer (.scl_in(scl), .sda_in(sda), .nack_in(nack),
		.ack_oe_out(ack_oe));
	// clock and hang guard
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 70000) begin
			err_total++;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one bus transfer, held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input int d);
		@(posedge clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= {2'h0, a, 2'h0};
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		@(posedge clk_in);
		while (pready_out !== 1'b1) @(posedge clk_in);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		xfer(1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input int e);
		xfer(0, a, 0);
		`CHK(rd, e)
	endtask
	// wait for the event interrupt, bounded
	task automatic wirq;
		n = 0;
		while (irq_out !== 1'b1 && n < 5000) begin
			@(posedge clk_in);
			n++;
		end
		`CHK(irq_out, 1'b1)
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		nrst_in <= 1;
		rc(`ITC_IDX_STATE, 8'hf8);
		rc(`ITC_IDX_CON, 0);
		rc(`ITC_IDX_TMO, 0);
		$display("reset test done");
		for (i = 0; i < 9; i++) begin
			j = rw[i % 3];
			m[j] = $random(seed) & 8'hff;
			wr(j, m[j]);
			rc(j, m[j]);
		end
		wr(`ITC_IDX_STATE, 0);
		rc(`ITC_IDX_STATE, 8'hf8);
		wr(0, 8'hff);
		rc(0, 0);
		`CHK(er, 1'b1)
		$display("register test done");
		wr(`ITC_IDX_IMSK, 3);
		wr(`ITC_IDX_RATE, 5);
		wr(`ITC_IDX_CON, 8'h60);
		wirq;
		rc(`ITC_IDX_STATE, 8'h08);
		rc(`ITC_IDX_IST, 1);
		for (i = 0; i < 2; i++) begin
			nack <= i[0];
			wr(`ITC_IDX_DATA, $random(seed) & 8'hfe);
			wr(`ITC_IDX_IST, 1);
			wr(`ITC_IDX_CON, 8'h44);
			`CHK(irq_out, 1'b0)
			wirq;
			rc(`ITC_IDX_STATE, i ? 8'h20 : 8'h18);
			if (i == 0) begin
				wr(`ITC_IDX_IST, 1);
				wr(`ITC_IDX_CON, 8'h64);
				wirq;
				rc(`ITC_IDX_STATE, 8'h10);
			end
		end
		wr(`ITC_IDX_IST, 1);
		wr(`ITC_IDX_CON, 8'h54);
		n = 0;
		do begin
			xfer(0, `ITC_IDX_CON, 0);
			n++;
		end while (rd[4] !== 1'b0 && n < 200);
		rc(`ITC_IDX_CON, 8'h44);
		rc(`ITC_IDX_STATE, 8'hf8);
		`CHK(irq_out, 1'b0)
		$display("master test done");
		wr(`ITC_IDX_TMO, 4);
		repeat (16000) @(posedge clk_in);
		rc(`ITC_IDX_TMO, 4);
		repeat (600) @(posedge clk_in);
		rc(`ITC_IDX_TMO, 5);
		rc(`ITC_IDX_IST, 2);
		wr(`ITC_IDX_IMSK, 1);
		rc(`ITC_IDX_IMSK, 1);
		`CHK(irq_out, 1'b0)
		wr(`ITC_IDX_IMSK, 3);
		wr(`ITC_IDX_TMO, 0);
		`CHK(irq_out, 1'b1)
		wr(`ITC_IDX_IST, 2);
		rc(`ITC_IDX_TMO, 0);
		`CHK(irq_out, 1'b0)
		for (i = 0; i < 2; i++) begin
			wr(`ITC_IDX_CON, i ? 0 : 8'h44);
			wr(`ITC_IDX_TMO, i ? 4 : 6);
			repeat (16600) @(posedge clk_in);
			rc(`ITC_IDX_TMO, i ? 4 : 6);
			wr(`ITC_IDX_TMO, 0);
		end
		$display("timeout test done");
		conclude;
	end
endmodule
`default_nettype wire
